// file: xbc_cfg.svh
// constants of the external bus controller: field positions, widths, codes
`ifndef XBC_CFG_SVH
`define XBC_CFG_SVH

// ==========================================================
// widths
`define XBC_ADDR_W      24
`define XBC_DATA_W      16
`define XBC_SEG_W       8
`define XBC_SEG_LO      16
`define XBC_CNT_W       4
`define XBC_WIN_IDX_W   3

// ==========================================================
// window function configuration fields
`define XBC_FN_W        5
`define XBC_FN_EN       0
`define XBC_FN_MUX      1
`define XBC_FN_W16      2
`define XBC_FN_RDY      3
`define XBC_FN_CS       4

// ==========================================================
// window timing configuration fields, counted in reference clock periods
`define XBC_TM_W        12
`define XBC_TM_SETUP    3:0
`define XBC_TM_WAIT     7:4
`define XBC_TM_HOLD     11:8

// ==========================================================
// window range select fields
`define XBC_RS_W        16
`define XBC_RS_SIZE_LO  0
`define XBC_RS_BASE_LO  4
`define XBC_RS_BASE_W   12
`define XBC_RS_MASK_ALL 12'hfff

// ==========================================================
// internal mirror bus address segment
`define XBC_MIR_TAG     8'h20

`endif

// file: xbc_ext_mem.sv
// partner model: external memory on the parallel bus with a programmable ready delay
`timescale 1ns/1ps
module xbc_ext_mem (
  // clock
  input  wire logic        clock,
  // bus pins from the controller
  input  wire logic [15:0] ad_out,
  input  wire logic [15:0] low_addr_out,
  input  wire logic [15:0] low_addr_oe,
  input  wire logic [7:0]  seg_addr_out,
  input  wire logic [7:0]  seg_addr_oe,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [4:0]  chip_select_n,
  // bus pins to the controller
  output logic      [15:0] ad_in,
  output logic             bus_ready_in,
  // model settings
  input  wire logic        bus16,
  input  wire logic        rdy_high,
  input  wire logic [3:0]  rdy_dly
);
  // ==========================================================
  // storage and address latch
  logic [7:0]  mem [0:65535];
  logic [23:0] addr;
  logic [3:0]  strobe_cnt;
  logic [15:0] ea;
  logic        strobe;
  logic [15:0] pat;
  assign ea     = {addr[15:1], addr[0] & ~bus16};
  assign strobe = ~rd_n | ~wr_n;
  // read data follows the strobe at once, like an asynchronous memory
  assign ad_in  = rd_n ? pat
                       : (bus16 ? {mem[ea | 16'h0001], mem[ea]} : {pat[15:8], mem[ea]});

  initial begin
    pat          = 16'h0000;
    bus_ready_in = 1'b0;
    addr         = 24'h000000;
    strobe_cnt   = 4'h0;
  end

  // ==========================================================
  // bus response, all changes after rising edges
  always @(posedge clock) begin
    if (chip_select_n != 5'h1f && rd_n && wr_n) begin
      if (ale)
        addr <= {seg_addr_out & seg_addr_oe, ad_out};
      else if (low_addr_oe != 16'h0000)
        addr <= {seg_addr_out & seg_addr_oe, low_addr_out};
    end
    // released data lines show a changing pattern
    pat <= ~pat;
    if (!wr_n) begin
      mem[ea] <= ad_out[7:0];
      if (bus16)
        mem[ea | 16'h0001] <= ad_out[15:8];
    end
    strobe_cnt <= !strobe ? 4'h0 : (strobe_cnt == 4'hf ? strobe_cnt : strobe_cnt + 4'h1);
    bus_ready_in <= (strobe && strobe_cnt >= rdy_dly) ? rdy_high : ~rdy_high;
  end
endmodule : xbc_ext_mem

// file: xbc_pkg.sv
// types shared by the external bus controller
package xbc_pkg;

  // ==========================================================
  // access sequencer states
  typedef enum logic [2:0] {
    XBC_IDLE,
    XBC_MIR,
    XBC_START,
    XBC_ADDR,
    XBC_ACC,
    XBC_HOLD
  } xbc_state_t;

endpackage : xbc_pkg

// file: xbc_top.sv
// external bus controller: window decode, bus sequencer, pin drivers
`timescale 1ns/1ps
`include "xbc_cfg.svh"

// Contract
// R1: every external memory access runs through this controller only.
// R2: internal mirror bus peripherals are served by the same controller.
// R3: internal and external resources share one linear 24-bit address space.
// R4: single-chip mode or external bus mode is selectable.
// R5: external address width is configurable from zero up to 24 bits.
// R6: external data path is 8 or 16 bits wide per configuration.
// R7: address and data share the multiplexed port in multiplexed operation.
// R8: demultiplexed operation also drives the low address on dedicated lines.
// R9: active segment address lines are selectable; unused lines are released.
// R10: one chip select per window plus one for the default region.
// R11: per-window timing and function configuration shapes each bus cycle.
// R12: ready input with selectable level stretches the access; device ends it.
// R13: up to four independent address windows selected by range settings.
// R14: overlapping windows: four beats three, two beats one.
// R15: an access hitting no window uses the default configuration.
// R16: the selected window asserts its chip select for the whole access.
// R17: bus timing is referenced to rising edges of the reference clock out.
// R18: width and multiplexing switch per access with the selected window.
// R19: single-chip mode starts no external cycle and releases bus pins.
module xbc_top #(
  parameter int NWIN     = 4,
  parameter int REF_HALF = 1
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // requester port
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic                          req_write,
  input  wire logic                          req_word,
  input  wire logic [`XBC_ADDR_W-1:0]        req_addr,
  input  wire logic [`XBC_DATA_W-1:0]        req_wdata,
  output logic                               rsp_valid,
  output logic                               rsp_error,
  output logic [`XBC_DATA_W-1:0]             rsp_rdata,
  // configuration
  input  wire logic                          single_chip,
  input  wire logic [4:0]                    addr_width,
  input  wire logic                          ready_active_high,
  input  wire logic [`XBC_TM_W-1:0]          default_timing_cfg,
  input  wire logic [`XBC_FN_W-1:0]          default_function_cfg,
  input  wire logic [NWIN*`XBC_RS_W-1:0]     window_range_select,
  input  wire logic [NWIN*`XBC_TM_W-1:0]     window_timing_cfg,
  input  wire logic [NWIN*`XBC_FN_W-1:0]     window_function_cfg,
  // status
  output logic                               busy,
  output logic [`XBC_WIN_IDX_W-1:0]          active_window,
  // external bus pins
  output logic                               bus_reference_clock_out,
  input  wire logic [`XBC_DATA_W-1:0]        ad_in,
  output logic [`XBC_DATA_W-1:0]             ad_out,
  output logic                               ad_oe,
  output logic [`XBC_DATA_W-1:0]             low_addr_out,
  output logic [`XBC_DATA_W-1:0]             low_addr_oe,
  output logic [`XBC_SEG_W-1:0]              seg_addr_out,
  output logic [`XBC_SEG_W-1:0]              seg_addr_oe,
  output logic                               ale,
  output logic                               rd_n,
  output logic                               wr_n,
  output logic [NWIN:0]                      chip_select_n,
  input  wire logic                          bus_ready_in,
  // internal mirror bus
  output logic                               mirror_strobe,
  output logic                               mirror_write,
  output logic [`XBC_ADDR_W-1:0]             mirror_addr,
  output logic [`XBC_DATA_W-1:0]             mirror_wdata,
  input  wire logic [`XBC_DATA_W-1:0]        mirror_rdata,
  input  wire logic                          mirror_ready
);

  // ==========================================================
  // elaboration checks
  if (NWIN < 1 || NWIN > 4) begin : g_bad_nwin
    $error("NWIN must lie between 1 and 4");
  end
  if (REF_HALF < 1 || REF_HALF > 255) begin : g_bad_ref
    $error("REF_HALF must lie between 1 and 255");
  end

  // ==========================================================
  // state
  xbc_pkg::xbc_state_t               state;
  logic [`XBC_ADDR_W-1:0]            cur_addr;
  logic [`XBC_DATA_W-1:0]            cur_wdata;
  logic                              cur_write;
  logic                              cur_word;
  logic [`XBC_TM_W-1:0]              cur_tm;
  logic [`XBC_FN_W-1:0]              cur_fn;
  logic [`XBC_WIN_IDX_W-1:0]         cur_win;
  logic                              second;
  logic                              upper;
  logic [`XBC_CNT_W-1:0]             cnt;
  logic [7:0]                        ref_cnt;
  logic                              ref_clk;

  // ==========================================================
  // reference clock divider
  wire ref_tick = (ref_cnt == 8'(REF_HALF - 1));
  wire ref_rise = ref_tick & ~ref_clk;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ref_cnt <= 8'h00;
      ref_clk <= 1'b0;
    end else begin
      ref_cnt <= ref_tick ? 8'h00 : ref_cnt + 8'h01;
      ref_clk <= ref_tick ? ~ref_clk : ref_clk;
    end
  end

  // ==========================================================
  // pin input synchroniser, a bit counts once stages two and three agree
  logic [`XBC_DATA_W:0] sy1;
  logic [`XBC_DATA_W:0] sy2;
  logic [`XBC_DATA_W:0] sy3;
  logic [`XBC_DATA_W:0] syf;
  wire  [`XBC_DATA_W:0] sy_diff = sy2 ^ sy3;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      syf <= '0;
    end else begin
      sy1 <= {bus_ready_in, ad_in};
      sy2 <= sy1;
      sy3 <= sy2;
      syf <= (~sy_diff & sy3) | (sy_diff & syf);
    end
  end

  wire                   rdy_ok  = ready_active_high ? syf[`XBC_DATA_W] : ~syf[`XBC_DATA_W];
  wire [`XBC_DATA_W-1:0] ad_sync = syf[`XBC_DATA_W-1:0];

  // ==========================================================
  // window decode
  logic [`XBC_TM_W-1:0] tm_tab [0:NWIN];
  logic [`XBC_FN_W-1:0] fn_tab [0:NWIN];
  logic [NWIN-1:0]      hit;

  assign tm_tab[0] = default_timing_cfg; // [R15]
  assign fn_tab[0] = default_function_cfg; // [R15]

  for (genvar g = 0; g < NWIN; g++) begin : g_win
    wire [`XBC_RS_BASE_W-1:0] base = window_range_select[g*`XBC_RS_W+`XBC_RS_BASE_LO +: `XBC_RS_BASE_W];
    wire [3:0]                size = window_range_select[g*`XBC_RS_W+`XBC_RS_SIZE_LO +: 4];
    wire [`XBC_RS_BASE_W-1:0] mask = `XBC_RS_MASK_ALL << size;
    wire [`XBC_FN_W-1:0]      fn   = window_function_cfg[g*`XBC_FN_W +: `XBC_FN_W];
    assign tm_tab[g+1] = window_timing_cfg[g*`XBC_TM_W +: `XBC_TM_W]; // [R11]
    assign fn_tab[g+1] = fn;
    assign hit[g] = fn[`XBC_FN_EN]
                    & (((req_addr[`XBC_ADDR_W-1 -: `XBC_RS_BASE_W] ^ base) & mask) == '0); // [R13]
  end

  // highest numbered window that hits wins
  logic [`XBC_WIN_IDX_W-1:0] sel;
  always_comb begin
    sel = '0;
    for (int i = 0; i < NWIN; i++) begin
      if (hit[i]) begin
        sel = `XBC_WIN_IDX_W'(i + 1); // [R14]
      end
    end
  end

  wire [`XBC_TM_W-1:0] sel_tm  = tm_tab[sel];
  wire [`XBC_FN_W-1:0] sel_fn  = fn_tab[sel];
  wire                 mir_hit = (req_addr[`XBC_ADDR_W-1 -: 8] == `XBC_MIR_TAG);
  wire                 accept  = req_valid & req_ready;
  wire                 cur_mux = cur_fn[`XBC_FN_MUX];
  wire                 cur_w16 = cur_fn[`XBC_FN_W16];
  wire                 acc_end = ref_rise & (cnt == '0)
                                 & (~cur_fn[`XBC_FN_RDY] | rdy_ok); // [R12]

  assign req_ready = (state == xbc_pkg::XBC_IDLE);

  // ==========================================================
  // read data steering per bus width
  wire [`XBC_DATA_W-1:0] rd_word = cur_word ? ad_sync
                                 : {8'h00, (cur_addr[0] ? ad_sync[15:8] : ad_sync[7:0])};
  wire [`XBC_DATA_W-1:0] rd_byte = upper ? {ad_sync[7:0], rsp_rdata[7:0]}
                                         : {rsp_rdata[15:8], ad_sync[7:0]};
  wire [`XBC_DATA_W-1:0] next_rdata = cur_w16 ? rd_word : rd_byte; // [R6]

  wire [`XBC_DATA_W-1:0] wr_word = cur_word ? cur_wdata : {cur_wdata[7:0], cur_wdata[7:0]};
  wire [`XBC_DATA_W-1:0] wr_byte = {8'h00, (upper ? cur_wdata[15:8] : cur_wdata[7:0])};
  wire [`XBC_DATA_W-1:0] wr_data = cur_w16 ? wr_word : wr_byte;

  // ==========================================================
  // access sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state     <= xbc_pkg::XBC_IDLE;
      cur_addr  <= '0;
      cur_wdata <= '0;
      cur_write <= 1'b0;
      cur_word  <= 1'b0;
      cur_tm    <= '0;
      cur_fn    <= '0;
      cur_win   <= '0;
      second    <= 1'b0;
      upper     <= 1'b0;
      cnt       <= '0;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        xbc_pkg::XBC_IDLE: begin
          if (accept) begin
            cur_addr  <= req_addr; // [R3]
            cur_wdata <= req_wdata;
            cur_write <= req_write;
            cur_word  <= req_word;
            upper     <= 1'b0;
            if (mir_hit) begin
              state <= xbc_pkg::XBC_MIR; // [R2]
            end else if (single_chip) begin // [R4]
              rsp_valid <= 1'b1; // [R19]
              rsp_error <= 1'b1;
            end else begin
              cur_win <= sel; // [R18]
              cur_tm  <= sel_tm;
              cur_fn  <= sel_fn;
              second  <= req_word & ~sel_fn[`XBC_FN_W16]; // [R6]
              state   <= xbc_pkg::XBC_START; // [R1]
            end
          end
        end
        xbc_pkg::XBC_MIR: begin
          if (mirror_ready & mirror_strobe) begin
            rsp_rdata <= mirror_rdata;
            rsp_error <= 1'b0;
            rsp_valid <= 1'b1;
            state     <= xbc_pkg::XBC_IDLE;
          end
        end
        xbc_pkg::XBC_START: begin
          if (ref_rise) begin
            cnt   <= cur_tm[`XBC_TM_SETUP]; // [R17]
            state <= xbc_pkg::XBC_ADDR;
          end
        end
        xbc_pkg::XBC_ADDR: begin
          if (ref_rise) begin
            if (cnt == '0) begin
              cnt   <= cur_tm[`XBC_TM_WAIT]; // [R11]
              state <= xbc_pkg::XBC_ACC;
            end else begin
              cnt <= cnt - `XBC_CNT_W'(1);
            end
          end
        end
        xbc_pkg::XBC_ACC: begin
          if (ref_rise & (cnt != '0)) begin
            cnt <= cnt - `XBC_CNT_W'(1);
          end else if (acc_end) begin
            if (!cur_write) begin
              rsp_rdata <= next_rdata;
            end
            cnt   <= cur_tm[`XBC_TM_HOLD];
            state <= xbc_pkg::XBC_HOLD;
          end
        end
        xbc_pkg::XBC_HOLD: begin
          if (ref_rise) begin
            if (cnt != '0) begin
              cnt <= cnt - `XBC_CNT_W'(1);
            end else if (second) begin
              second   <= 1'b0;
              upper    <= 1'b1; // [R6]
              cur_addr <= cur_addr + `XBC_ADDR_W'(1);
              cnt      <= cur_tm[`XBC_TM_SETUP];
              state    <= xbc_pkg::XBC_ADDR;
            end else begin
              rsp_error <= 1'b0;
              rsp_valid <= 1'b1;
              state     <= xbc_pkg::XBC_IDLE;
            end
          end
        end
        default: begin
          state <= xbc_pkg::XBC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin value decode
  wire in_addr  = (state == xbc_pkg::XBC_ADDR);
  wire in_acc   = (state == xbc_pkg::XBC_ACC);
  wire in_cycle = in_addr | in_acc | (state == xbc_pkg::XBC_HOLD);
  wire drive_wr = cur_write & (in_acc | (state == xbc_pkg::XBC_HOLD));

  logic [`XBC_DATA_W-1:0] low_mask;
  logic [`XBC_SEG_W-1:0]  seg_mask;
  for (genvar b = 0; b < `XBC_DATA_W; b++) begin : g_low
    assign low_mask[b] = (addr_width > 5'(b)); // [R5]
  end
  for (genvar b = 0; b < `XBC_SEG_W; b++) begin : g_seg
    assign seg_mask[b] = (addr_width > 5'(b + `XBC_SEG_LO)); // [R9]
  end

  wire [`XBC_DATA_W-1:0] next_ad    = (in_addr & cur_mux) ? cur_addr[`XBC_DATA_W-1:0] : wr_data;
  wire                   next_ad_oe = (in_addr & cur_mux) | drive_wr; // [R7]
  wire [`XBC_DATA_W-1:0] next_low_oe = (in_cycle & ~cur_mux) ? low_mask : '0; // [R8]
  wire [`XBC_SEG_W-1:0]  next_seg_oe = single_chip ? '0 : seg_mask; // [R19]

  logic [NWIN:0] next_cs_n;
  always_comb begin
    next_cs_n = '1;
    if (in_cycle & cur_fn[`XBC_FN_CS]) begin
      next_cs_n[cur_win] = 1'b0; // [R10] [R16]
    end
  end

  // ==========================================================
  // registered pin drivers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ad_out        <= '0;
      ad_oe         <= 1'b0;
      low_addr_out  <= '0;
      low_addr_oe   <= '0;
      seg_addr_out  <= '0;
      seg_addr_oe   <= '0;
      ale           <= 1'b0;
      rd_n          <= 1'b1;
      wr_n          <= 1'b1;
      chip_select_n <= '1;
      mirror_strobe <= 1'b0;
      busy          <= 1'b0;
    end else begin
      ad_out        <= next_ad;
      ad_oe         <= next_ad_oe;
      low_addr_out  <= cur_addr[`XBC_DATA_W-1:0];
      low_addr_oe   <= next_low_oe;
      seg_addr_out  <= cur_addr[`XBC_ADDR_W-1 -: `XBC_SEG_W];
      seg_addr_oe   <= next_seg_oe;
      ale           <= in_addr & cur_mux;
      rd_n          <= ~(in_acc & ~cur_write);
      wr_n          <= ~(in_acc & cur_write);
      chip_select_n <= next_cs_n;
      mirror_strobe <= (state == xbc_pkg::XBC_MIR) & ~(mirror_ready & mirror_strobe);
      busy          <= (state != xbc_pkg::XBC_IDLE);
    end
  end

  assign bus_reference_clock_out = ref_clk;
  assign active_window           = cur_win;
  assign mirror_write            = cur_write;
  assign mirror_addr             = cur_addr;
  assign mirror_wdata            = cur_wdata;

  // ==========================================================
  // checks
  property p_single_chip_refuse;
    @(posedge clock) disable iff (reset)
      (accept & single_chip & ~mir_hit) |=> (rsp_valid & rsp_error & req_ready);
  endproperty
  a_single_chip_refuse: assert property (p_single_chip_refuse) // [R19]
    else $error("single-chip access not refused at once");

  property p_idle_quiet;
    @(posedge clock) disable iff (reset)
      (state == xbc_pkg::XBC_IDLE) && $past(state == xbc_pkg::XBC_IDLE) |-> (rd_n & wr_n & ~ad_oe);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // [R1]
    else $error("bus strobes active with no access in progress");

  property p_priority;
    @(posedge clock) disable iff (reset)
      (accept & ~single_chip & ~mir_hit & hit[NWIN-1]) |=> (cur_win == `XBC_WIN_IDX_W'(NWIN));
  endproperty
  a_priority: assert property (p_priority) // [R14]
    else $error("higher window did not take priority");

  property p_default_region;
    @(posedge clock) disable iff (reset)
      (accept & ~single_chip & ~mir_hit & (hit == '0)) |=> (cur_win == '0) && (cur_tm == $past(default_timing_cfg));
  endproperty
  a_default_region: assert property (p_default_region) // [R15]
    else $error("unmatched access did not use default region");

  property p_chip_select;
    @(posedge clock) disable iff (reset)
      (in_acc & cur_fn[`XBC_FN_CS]) |=> (chip_select_n[$past(cur_win)] == 1'b0) && (rd_n ^ wr_n);
  endproperty
  a_chip_select: assert property (p_chip_select) // [R16]
    else $error("chip select missing during access");

  property p_ready_stretch;
    @(posedge clock) disable iff (reset)
      (in_acc & ref_rise & (cnt == '0) & cur_fn[`XBC_FN_RDY] & ~rdy_ok) |=> in_acc;
  endproperty
  a_ready_stretch: assert property (p_ready_stretch) // [R12]
    else $error("access ended without ready");

  property p_ale_phase;
    @(posedge clock) disable iff (reset)
      ale |-> ($past(state) == xbc_pkg::XBC_ADDR) && ad_oe && (ad_out == $past(cur_addr[15:0]));
  endproperty
  a_ale_phase: assert property (p_ale_phase) // [R7]
    else $error("address latch strobe outside address phase");

  property p_demux_addr;
    @(posedge clock) disable iff (reset)
      (in_acc & ~cur_mux) |=> (low_addr_out == $past(cur_addr[15:0])) && ~ale;
  endproperty
  a_demux_addr: assert property (p_demux_addr) // [R8]
    else $error("demultiplexed address not on dedicated lines");

  property p_ref_edge;
    @(posedge clock) disable iff (reset)
      (state == xbc_pkg::XBC_ADDR) && ($past(state) == xbc_pkg::XBC_START) |-> ref_clk;
  endproperty
  a_ref_edge: assert property (p_ref_edge) // [R17]
    else $error("bus cycle not aligned to reference clock rise");

  property p_byte_bus_split;
    @(posedge clock) disable iff (reset)
      (state == xbc_pkg::XBC_HOLD) && ref_rise && (cnt == '0) && second
        |=> (state == xbc_pkg::XBC_ADDR) && upper
            && (cur_addr == $past(cur_addr) + `XBC_ADDR_W'(1));
  endproperty
  a_byte_bus_split: assert property (p_byte_bus_split) // [R6]
    else $error("word on byte bus not split in two cycles");

endmodule : xbc_top

// file: xbc_top_tb.sv
// self-checking testbench of the external bus controller
`timescale 1ns/1ps
module xbc_top_tb;
  logic        clock, reset, req_valid, req_ready, req_write, req_word;
  logic [23:0] req_addr, mirror_addr;
  logic [15:0] req_wdata, rsp_rdata, ad_in, ad_out, low_addr_out, low_addr_oe;
  logic [15:0] mirror_wdata, mirror_rdata;
  logic        rsp_valid, rsp_error, single_chip, ready_active_high, busy, refclk;
  logic [4:0]  addr_width, default_function_cfg, chip_select_n, cs_seen;
  logic [11:0] default_timing_cfg;
  logic [63:0] wrs;
  logic [47:0] wtc;
  logic [19:0] wfc;
  logic [2:0]  active_window;
  logic [7:0]  seg_addr_out, seg_addr_oe, seg_seen;
  logic        ad_oe, ale, rd_n, wr_n, bus_ready_in, mirror_strobe, mirror_write;
  logic        mirror_ready, bus16, ale_seen;
  logic [3:0]  rdy_dly;
  int          fails, num_checks, rd_low, cycles;

  xbc_top i_dut (.clock(clock), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_word(req_word),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .single_chip(single_chip),
    .addr_width(addr_width), .ready_active_high(ready_active_high),
    .default_timing_cfg(default_timing_cfg), .default_function_cfg(default_function_cfg),
    .window_range_select(wrs), .window_timing_cfg(wtc), .window_function_cfg(wfc),
    .busy(busy), .active_window(active_window), .bus_reference_clock_out(refclk),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .low_addr_out(low_addr_out),
    .low_addr_oe(low_addr_oe), .seg_addr_out(seg_addr_out), .seg_addr_oe(seg_addr_oe),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .chip_select_n(chip_select_n),
    .bus_ready_in(bus_ready_in), .mirror_strobe(mirror_strobe),
    .mirror_write(mirror_write), .mirror_addr(mirror_addr), .mirror_wdata(mirror_wdata),
    .mirror_rdata(mirror_rdata), .mirror_ready(mirror_ready));

  xbc_ext_mem i_mem (.clock(clock), .ad_out(ad_out), .low_addr_out(low_addr_out),
    .low_addr_oe(low_addr_oe), .seg_addr_out(seg_addr_out), .seg_addr_oe(seg_addr_oe),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .chip_select_n(chip_select_n), .ad_in(ad_in),
    .bus_ready_in(bus_ready_in), .bus16(bus16), .rdy_high(ready_active_high),
    .rdy_dly(rdy_dly));

  // ==========================================================
  // clock, mirror peripheral, pin monitor, hang limit
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(negedge clock) begin
    mirror_ready = mirror_strobe;
    mirror_rdata = mirror_strobe ? mirror_addr[15:0] ^ 16'h3c3c : 16'h0000;
  end

  always @(posedge clock) begin
    cs_seen  <= cs_seen | ~chip_select_n;
    seg_seen <= seg_seen | seg_addr_oe;
    ale_seen <= ale_seen | ale;
    rd_low   <= rd_low + int'(!rd_n);
    cycles   <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic results();
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clock);
    chk(24'(busy), 24'h000000);
    cs_seen = 5'h00;
    seg_seen = 8'h00;
    ale_seen = 1'b0;
    rd_low = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk(24'(n < 400), 24'h000001);
  endtask : acc

  // ==========================================================
  // scenarios
  task automatic t_single();
    single_chip = 1'b1;
    acc(1'b0, 24'h400000, 16'h0000);
    chk(24'(rsp_error), 24'h000001);
    chk(24'(cs_seen), 24'h000000);
    chk(24'(ale_seen), 24'h000000);
    chk(24'(seg_seen), 24'h000000);
    acc(1'b1, 24'h200020, 16'h5a5a);
    chk(24'({mirror_write, mirror_wdata}), 24'h015a5a);
    chk(mirror_addr, 24'h200020);
    acc(1'b0, 24'h200010, 16'h0000);
    chk(24'(rsp_error), 24'h000000);
    chk(24'(rsp_rdata), 24'h003c2c);
    chk(24'(cs_seen), 24'h000000);
    single_chip = 1'b0;
  endtask : t_single

  task automatic t_default();
    bus16 = 1'b1;
    acc(1'b1, 24'h500100, 16'h1234);
    chk(24'(cs_seen), 24'h000001);
    chk(24'(active_window), 24'h000000);
    acc(1'b0, 24'h500100, 16'h0000);
    chk(24'(rsp_rdata), 24'h001234);
    chk(24'(ale_seen), 24'h000001);
    chk(24'(seg_seen), 24'h0000ff);
    default_timing_cfg = 12'h060;
    addr_width = 5'd20;
    acc(1'b0, 24'h500100, 16'h0000);
    chk(24'(rd_low), 24'h00000e);
    chk(24'(seg_seen), 24'h00000f);
    chk(24'(rsp_rdata), 24'h001234);
    default_timing_cfg = 12'h020;
    addr_width = 5'd24;
  endtask : t_default

  task automatic t_windows();
    logic [23:0] a [4] = '{24'h400800, 24'h401000, 24'h410000, 24'h411000};
    logic [2:0]  w [4] = '{3'd2, 3'd1, 3'd4, 3'd3};
    for (int i = 0; i < 4; i++) begin
      bus16 = w[i][0];
      acc(1'b1, a[i], 16'ha50f ^ 16'(i));
      chk(24'(active_window), 24'(w[i]));
      chk(24'(cs_seen), 24'(5'h01 << w[i]));
      acc(1'b0, a[i], 16'h0000);
      chk(24'(rsp_rdata), 24'(16'ha50f ^ 16'(i)));
      chk(24'(ale_seen), 24'(w[i] == 3'd1 || w[i] == 3'd4));
    end
  endtask : t_windows

  task automatic t_ready();
    bus16 = 1'b1;
    rdy_dly = 4'd12;
    for (int p = 0; p < 2; p++) begin
      ready_active_high = p[0];
      acc(1'b1, 24'h412040, 16'h7e81 ^ 16'(p));
      acc(1'b0, 24'h412040, 16'h0000);
      chk(24'(rsp_rdata), 24'(16'h7e81 ^ 16'(p)));
      chk(24'(rd_low >= 12), 24'h000001);
      chk(24'(active_window), 24'h000003);
    end
    rdy_dly = 4'd0;
  endtask : t_ready

  // ==========================================================
  // main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    cycles = 0;
    rd_low = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_word = 1'b1;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    single_chip = 1'b0;
    addr_width = 5'd24;
    ready_active_high = 1'b1;
    default_timing_cfg = 12'h020;
    default_function_cfg = 5'h16;
    wrs = {16'h4100, 16'h4104, 16'h4000, 16'h4004};
    wtc = {4{12'h020}};
    wfc = {5'h13, 5'h1d, 5'h11, 5'h17};
    mirror_ready = 1'b0;
    mirror_rdata = 16'h0000;
    bus16 = 1'b1;
    rdy_dly = 4'd0;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    t_single();
    t_default();
    t_windows();
    t_ready();
    results();
  end
endmodule : xbc_top_tb
